// File: hw/cpu_evt_pkg.sv
// constants for the core event entry and debug mode logic
package cpu_evt_pkg;
  localparam int          NUM_EVT        = 8;
  localparam int          EVT_W          = 3;
  localparam int          NUM_PROT       = 8;
  localparam int          AUTOVEC_W      = 14;
  localparam int          AUTOVEC_BYTES  = 16384;

  localparam logic [31:0] RESET_VECTOR   = 32'h8000_0000;

  // event slots, lower index wins
  localparam int          EVT_I_MULTI    = 0;
  localparam int          EVT_I_MISS     = 1;
  localparam int          EVT_I_PROT     = 2;
  localparam int          EVT_D_MULTI    = 3;
  localparam int          EVT_D_MISS     = 4;
  localparam int          EVT_D_PROT     = 5;
  localparam int          EVT_SCALL      = 6;
  localparam int          EVT_IRQ        = 7;

  // handler offsets from the event vector base
  localparam logic [13:0] OFS_I_MULTI    = 14'h000c;
  localparam logic [13:0] OFS_I_PROT     = 14'h0014;
  localparam logic [13:0] OFS_D_MULTI    = 14'h0010;
  localparam logic [13:0] OFS_D_PROT     = 14'h0018;
  localparam logic [13:0] OFS_DEBUG      = 14'h001c;
  localparam logic [13:0] OFS_I_MISS     = 14'h0050;
  localparam logic [13:0] OFS_D_MISS     = 14'h0060;
  localparam logic [13:0] OFS_SCALL      = 14'h0100;

  // status register layout
  localparam int          SR_DM_BIT      = 21;
  localparam int          SR_MODE_LO     = 22;
  localparam int          SR_MODE_HI     = 24;
  localparam int          SR_D_BIT       = 30;
  localparam logic [31:0] SR_RESET       = 32'h0040_0000;

  localparam logic [2:0]  MODE_APP       = 3'h0;
  localparam logic [2:0]  MODE_SUP       = 3'h1;
  localparam logic [2:0]  MODE_INT0      = 3'h2;
  localparam logic [2:0]  MODE_EXC       = 3'h6;

  typedef enum logic [1:0] {
    ST_BOOT  = 2'h0,
    ST_RUN   = 2'h1,
    ST_DEBUG = 2'h3
  } core_state_e;

  function automatic logic [13:0] evt_offset(input logic [2:0] code);
    case (code)
      3'h0:    evt_offset = OFS_I_MULTI;
      3'h1:    evt_offset = OFS_I_MISS;
      3'h2:    evt_offset = OFS_I_PROT;
      3'h3:    evt_offset = OFS_D_MULTI;
      3'h4:    evt_offset = OFS_D_MISS;
      3'h5:    evt_offset = OFS_D_PROT;
      3'h6:    evt_offset = OFS_SCALL;
      default: evt_offset = 14'h0000;
    endcase
  endfunction

  function automatic logic [31:0] with_mode(input logic [31:0] sr, input logic [2:0] m);
    logic [31:0] r;
    r = sr;
    r[SR_MODE_HI:SR_MODE_LO] = m;
    with_mode = r;
  endfunction
endpackage

// File: hw/evt_prio_pick.sv
// fixed priority picker, lowest set index wins
`timescale 1ns/100ps
`default_nettype none
module evt_prio_pick #(
  parameter int N = 8,
  parameter int W = 3
) (
  // request vector
  input  wire logic [N-1:0] req,
  // winner
  output logic              valid,
  output logic [W-1:0]      idx
);
  always_comb begin
    valid = 1'b0;
    idx   = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (req[i]) begin
        valid = 1'b1;
        idx   = W'(i);
      end
    end
  end
endmodule // evt_prio_pick
`default_nettype wire

// File: hw/prot_check.sv
// classifies one access against the protection entry hits
`timescale 1ns/100ps
`default_nettype none
module prot_check #(
  parameter int N = 8
) (
  // access and per-entry results
  input  wire logic         acc_valid,
  input  wire logic [N-1:0] hit,
  input  wire logic [N-1:0] perm_ok,
  // exception classes
  output logic              miss,
  output logic              multi,
  output logic              viol
);
  localparam int CW = $clog2(N + 1);
  logic [CW-1:0] cnt;

  always_comb begin
    cnt = '0;
    for (int i = 0; i < N; i++) begin
      cnt = cnt + CW'(hit[i]);
    end
    miss  = acc_valid && (cnt == '0);
    multi = acc_valid && (cnt > CW'(1));
    // a lone hit still faults if its permission is missing
    viol  = acc_valid && (cnt == CW'(1)) && ((hit & ~perm_ok) != '0);
  end
endmodule // prot_check
`default_nettype wire

// File: hw/cpu_event_debug_entry.sv
// event entry, vectoring and debug mode control of the core
//
// Overview of operation
// - A debug request enters Debug mode unless the status debug mask bit is set.
// - Entry sets the debug-active flag and redirects fetch to the debug handler.
// - Debug mode runs in exception context and saves pc and status in debug return registers.
// - In Debug mode the status mode bits may be written freely.
// - The debug return instruction leaves Debug mode and restores the saved context.
// - After reset fetching starts at the fixed reset vector in boot flash.
// - Miss exceptions and supervisor calls use dedicated offsets, each other exception its own.
// - Protection violations and unmatched addresses raise protection and miss exceptions.
// - An address matching several protection entries raises the multiple-hit exception.
// - Interrupt handlers sit at the base plus a 14-bit autovector from the controller.
// - Several events on one instruction are serviced in a fixed priority order.
// - Events on the oldest instruction go before those on younger ones.
// - Supervisor call and return push and pop return address and status on the stack.
// - Supervisor return restores the context the call was issued from.
`timescale 1ns/100ps
`default_nettype none
module cpu_event_debug_entry
  import cpu_evt_pkg::*;
(
  // clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 sys_rst,
  // pipeline context
  input  wire logic [31:0]          event_vector_base,
  input  wire logic [31:0]          ret_pc,
  input  wire logic [NUM_EVT-1:0]   old_evt,
  input  wire logic [NUM_EVT-1:0]   young_evt,
  // protection checks
  input  wire logic                 instr_acc_valid,
  input  wire logic [NUM_PROT-1:0]  instr_hit,
  input  wire logic [NUM_PROT-1:0]  instr_perm_ok,
  input  wire logic                 data_acc_valid,
  input  wire logic [NUM_PROT-1:0]  data_hit,
  input  wire logic [NUM_PROT-1:0]  data_perm_ok,
  // interrupt controller
  input  wire logic [AUTOVEC_W-1:0] irq_autovec,
  // debug module and return instructions
  input  wire logic                 dbg_req,
  input  wire logic                 retd_exec,
  input  wire logic                 rets_exec,
  input  wire logic [31:0]          stack_ret_pc,
  input  wire logic [31:0]          stack_ret_sr,
  // status register writes
  input  wire logic                 sr_wr_en,
  input  wire logic [31:0]          sr_wr_data,
  // fetch redirect
  output logic                      fetch_redirect_q,
  output logic [31:0]               fetch_addr_q,
  // status and debug state
  output logic [31:0]               sr_q,
  output logic                      debug_active_flag_q,
  output logic [31:0]               dbg_ret_pc_q,
  output logic [31:0]               dbg_ret_sr_q,
  // system stack
  output logic                      stack_push_q,
  output logic [31:0]               stack_push_pc_q,
  output logic [31:0]               stack_push_sr_q,
  output logic                      stack_pop_q,
  // event report
  output logic                      evt_taken_q,
  output logic [EVT_W-1:0]          evt_code_q,
  output logic                      evt_old_q
);
  core_state_e        state_q, state_d;
  logic               fetch_redirect_d;
  logic [31:0]        fetch_addr_d, sr_d, dbg_ret_pc_d, dbg_ret_sr_d;
  logic               stack_push_d, stack_pop_d, evt_taken_d, evt_old_d;
  logic [31:0]        stack_push_pc_d, stack_push_sr_d;
  logic [EVT_W-1:0]   evt_code_d;

  logic               i_miss, i_multi, i_viol, d_miss, d_multi, d_viol;
  logic [NUM_EVT-1:0] old_vec, young_vec;
  logic               old_v, young_v, evt_any;
  logic [EVT_W-1:0]   old_idx, young_idx, take_idx;
  logic               dbg_enter;
  logic [31:0]        sr_wr_mask;

  prot_check #(.N(NUM_PROT)) u_instr_protection_check (
    .acc_valid (instr_acc_valid),
    .hit       (instr_hit),
    .perm_ok   (instr_perm_ok),
    .miss      (i_miss),
    .multi     (i_multi),
    .viol      (i_viol)
  );

  prot_check #(.N(NUM_PROT)) u_data_protection_check (
    .acc_valid (data_acc_valid),
    .hit       (data_hit),
    .perm_ok   (data_perm_ok),
    .miss      (d_miss),
    .multi     (d_multi),
    .viol      (d_viol)
  );

  // fetch-side checks belong to the younger instruction, data-side to the oldest
  always_comb begin
    old_vec                = old_evt;
    old_vec[EVT_D_MULTI]   = old_evt[EVT_D_MULTI] | d_multi;
    old_vec[EVT_D_MISS]    = old_evt[EVT_D_MISS] | d_miss;
    old_vec[EVT_D_PROT]    = old_evt[EVT_D_PROT] | d_viol;
    young_vec              = young_evt;
    young_vec[EVT_I_MULTI] = young_evt[EVT_I_MULTI] | i_multi;
    young_vec[EVT_I_MISS]  = young_evt[EVT_I_MISS] | i_miss;
    young_vec[EVT_I_PROT]  = young_evt[EVT_I_PROT] | i_viol;
  end

  evt_prio_pick #(.N(NUM_EVT), .W(EVT_W)) u_old_pick (
    .req   (old_vec),
    .valid (old_v),
    .idx   (old_idx)
  );

  evt_prio_pick #(.N(NUM_EVT), .W(EVT_W)) u_young_pick (
    .req   (young_vec),
    .valid (young_v),
    .idx   (young_idx)
  );

  assign evt_any   = (state_q != ST_BOOT) && (old_v || young_v);
  assign take_idx  = old_v ? old_idx : young_idx;
  assign dbg_enter = (state_q == ST_RUN) && !evt_any && !rets_exec && dbg_req
                     && !sr_q[SR_DM_BIT];

  // the debug flag stays hardware owned; mode and mask need privilege outside debug
  always_comb begin
    sr_wr_mask           = 32'hffff_ffff;
    sr_wr_mask[SR_D_BIT] = 1'b0;
    if (state_q != ST_DEBUG && sr_q[SR_MODE_HI:SR_MODE_LO] == MODE_APP) begin
      sr_wr_mask[SR_MODE_HI:SR_MODE_LO] = 3'h0;
      sr_wr_mask[SR_DM_BIT]             = 1'b0;
    end
  end

  always_comb begin
    state_d          = state_q;
    fetch_redirect_d = 1'b0;
    fetch_addr_d     = fetch_addr_q;
    sr_d             = sr_q;
    dbg_ret_pc_d     = dbg_ret_pc_q;
    dbg_ret_sr_d     = dbg_ret_sr_q;
    stack_push_d     = 1'b0;
    stack_push_pc_d  = stack_push_pc_q;
    stack_push_sr_d  = stack_push_sr_q;
    stack_pop_d      = 1'b0;
    evt_taken_d      = 1'b0;
    evt_code_d       = evt_code_q;
    evt_old_d        = evt_old_q;
    case (state_q)
      ST_BOOT: begin
        fetch_redirect_d = 1'b1;
        fetch_addr_d     = RESET_VECTOR;
        state_d          = ST_RUN;
      end
      ST_RUN, ST_DEBUG: begin
        if (evt_any) begin
          fetch_redirect_d = 1'b1;
          evt_taken_d      = 1'b1;
          evt_code_d       = take_idx;
          evt_old_d        = old_v;
          if (take_idx == EVT_W'(EVT_IRQ)) begin
            fetch_addr_d = event_vector_base + {18'h0, irq_autovec};
            sr_d         = with_mode(sr_q, MODE_INT0);
          end else if (take_idx == EVT_W'(EVT_SCALL)) begin
            fetch_addr_d    = event_vector_base + {18'h0, OFS_SCALL};
            sr_d            = with_mode(sr_q, MODE_SUP);
            stack_push_d    = 1'b1;
            stack_push_pc_d = ret_pc;
            stack_push_sr_d = sr_q;
          end else begin
            fetch_addr_d = event_vector_base + {18'h0, evt_offset(take_idx)};
            sr_d         = with_mode(sr_q, MODE_EXC);
          end
        end else if (state_q == ST_DEBUG && retd_exec) begin
          fetch_redirect_d = 1'b1;
          fetch_addr_d     = dbg_ret_pc_q;
          sr_d             = dbg_ret_sr_q;
          sr_d[SR_D_BIT]   = 1'b0;
          state_d          = ST_RUN;
        end else if (rets_exec) begin
          // popped words arrive alongside the return instruction
          fetch_redirect_d = 1'b1;
          stack_pop_d      = 1'b1;
          fetch_addr_d     = stack_ret_pc;
          sr_d             = stack_ret_sr;
          sr_d[SR_D_BIT]   = sr_q[SR_D_BIT];
        end else if (dbg_enter) begin
          fetch_redirect_d = 1'b1;
          fetch_addr_d     = event_vector_base + {18'h0, OFS_DEBUG};
          dbg_ret_pc_d     = ret_pc;
          dbg_ret_sr_d     = sr_q;
          sr_d             = with_mode(sr_q, MODE_EXC);
          sr_d[SR_D_BIT]   = 1'b1;
          state_d          = ST_DEBUG;
        end else if (sr_wr_en) begin
          sr_d = (sr_q & ~sr_wr_mask) | (sr_wr_data & sr_wr_mask);
        end
      end
      default: begin
        state_d = ST_BOOT;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      state_q          <= ST_BOOT;
      fetch_redirect_q <= 1'b0;
      fetch_addr_q     <= RESET_VECTOR;
      sr_q             <= SR_RESET;
      dbg_ret_pc_q     <= 32'h0000_0000;
      dbg_ret_sr_q     <= 32'h0000_0000;
      stack_push_q     <= 1'b0;
      stack_push_pc_q  <= 32'h0000_0000;
      stack_push_sr_q  <= 32'h0000_0000;
      stack_pop_q      <= 1'b0;
      evt_taken_q      <= 1'b0;
      evt_code_q       <= '0;
      evt_old_q        <= 1'b0;
    end else begin
      state_q          <= state_d;
      fetch_redirect_q <= fetch_redirect_d;
      fetch_addr_q     <= fetch_addr_d;
      sr_q             <= sr_d;
      dbg_ret_pc_q     <= dbg_ret_pc_d;
      dbg_ret_sr_q     <= dbg_ret_sr_d;
      stack_push_q     <= stack_push_d;
      stack_push_pc_q  <= stack_push_pc_d;
      stack_push_sr_q  <= stack_push_sr_d;
      stack_pop_q      <= stack_pop_d;
      evt_taken_q      <= evt_taken_d;
      evt_code_q       <= evt_code_d;
      evt_old_q        <= evt_old_d;
    end
  end

  // flag mirrors the status bit so both always agree
  assign debug_active_flag_q = sr_q[SR_D_BIT];

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  a_dbg_mask_hold: assert property (
    (state_q == ST_RUN && dbg_req && sr_q[SR_DM_BIT] && !evt_any && !rets_exec)
    |=> (state_q == ST_RUN) && !debug_active_flag_q)
    else $error("debug entry taken while masked");

  a_dbg_entry_vec: assert property (
    dbg_enter |=> debug_active_flag_q && fetch_redirect_q
    && fetch_addr_q == $past(event_vector_base) + {18'h0, OFS_DEBUG})
    else $error("debug entry did not reach handler");

  a_dbg_ret_save: assert property (
    dbg_enter |=> dbg_ret_pc_q == $past(ret_pc) && dbg_ret_sr_q == $past(sr_q)
    && !stack_push_q && sr_q[SR_MODE_HI:SR_MODE_LO] == MODE_EXC)
    else $error("debug return registers not saved");

  a_dbg_mode_write: assert property (
    (state_q == ST_DEBUG && sr_wr_en && !evt_any && !retd_exec && !rets_exec)
    |=> sr_q[SR_MODE_HI:SR_MODE_LO] == $past(sr_wr_data[SR_MODE_HI:SR_MODE_LO]))
    else $error("mode write refused in debug mode");

  a_dbg_exit_ctx: assert property (
    (state_q == ST_DEBUG && retd_exec && !evt_any)
    |=> !debug_active_flag_q && fetch_addr_q == $past(dbg_ret_pc_q)
    && state_q == ST_RUN)
    else $error("debug return did not restore context");

  a_reset_vector: assert property (
    $fell(sys_rst) |=> fetch_redirect_q && fetch_addr_q == RESET_VECTOR)
    else $error("reset fetch not at reset vector");

  a_scall_vector: assert property (
    (evt_any && take_idx == EVT_W'(EVT_SCALL))
    |=> fetch_addr_q == $past(event_vector_base) + {18'h0, OFS_SCALL})
    else $error("supervisor call vector wrong");

  a_dmiss_class: assert property (
    (data_acc_valid && data_hit == '0) |-> d_miss && !d_viol && !d_multi)
    else $error("unmatched data access not a miss");

  a_multi_hit: assert property (
    (instr_acc_valid && $countones(instr_hit) > 1) |-> i_multi && !i_miss)
    else $error("multiple hit not flagged");

  a_irq_autovec: assert property (
    (evt_any && take_idx == EVT_W'(EVT_IRQ))
    |=> fetch_addr_q - $past(event_vector_base) < AUTOVEC_BYTES
    && fetch_addr_q == $past(event_vector_base) + {18'h0, $past(irq_autovec)})
    else $error("interrupt handler address wrong");

  a_prio_order: assert property (
    (evt_any && old_vec[EVT_D_MULTI] && old_vec[EVT_D_PROT])
    |=> evt_code_q == EVT_W'(EVT_D_MULTI))
    else $error("lower priority event serviced first");

  a_old_first: assert property (
    (evt_any && old_v && young_v) |=> evt_taken_q && evt_old_q && evt_code_q == $past(old_idx))
    else $error("younger event serviced before oldest");

  a_scall_push: assert property (
    (evt_any && take_idx == EVT_W'(EVT_SCALL))
    |=> stack_push_q && stack_push_pc_q == $past(ret_pc) && stack_push_sr_q == $past(sr_q)
    ##1 (!stack_push_q || $past(evt_any && take_idx == EVT_W'(EVT_SCALL))))
    else $error("supervisor call did not push once");

  a_rets_restore: assert property (
    (rets_exec && !evt_any && state_q == ST_RUN)
    |=> stack_pop_q && fetch_addr_q == $past(stack_ret_pc)
    && sr_q[SR_MODE_HI:SR_MODE_LO] == $past(stack_ret_sr[SR_MODE_HI:SR_MODE_LO]))
    else $error("supervisor return did not restore context");

  a_no_nesting: assert property (
    (state_q == ST_DEBUG && dbg_req)
    |=> $stable(dbg_ret_pc_q) && $stable(dbg_ret_sr_q))
    else $error("debug request nested in debug mode");
endmodule // cpu_event_debug_entry
`default_nettype wire

// File: testbench/dbg_irq_model.sv
// debug module and interrupt controller model facing the event entry logic
`timescale 1ns/100ps
`default_nettype none
module dbg_irq_model
  import cpu_evt_pkg::*;
(
  // bench commands
  input  wire logic                 dbg_go,
  input  wire logic [15:0]          vec_sel,
  // lines into the core
  output logic                      dbg_req,
  output logic [AUTOVEC_W-1:0]      irq_autovec
);
  // a debugger holds its request as a level until told to drop it
  assign dbg_req     = dbg_go;
  // the controller only ever hands out 14 offset bits, upper bits are lost
  assign irq_autovec = vec_sel[AUTOVEC_W-1:0];
endmodule // dbg_irq_model
`default_nettype wire

// File: testbench/test_cpu_event_debug_entry.sv
// self-checking bench for the event entry and debug mode logic
`timescale 1ns/100ps
`default_nettype none
module test_cpu_event_debug_entry
  import cpu_evt_pkg::*;
;
  typedef struct packed {
    logic [7:0] oe;
    logic [7:0] ye;
    logic [1:0] acc;
    logic [7:0] hit;
    logic [7:0] ok;
    logic [2:0] code;
    logic       old;
  } row_s;

  logic ref_clk = 1'b0, sys_rst = 1'b1, dbg_go = 1'b0, dbg_req;
  logic [31:0] event_vector_base = 32'h0001_0000, ret_pc = 32'h0000_0200;
  logic [7:0]  old_evt = '0, young_evt = '0;
  logic        instr_acc_valid = 1'b0, data_acc_valid = 1'b0;
  logic [7:0]  instr_hit = '0, instr_perm_ok = '0, data_hit = '0, data_perm_ok = '0;
  logic [15:0] vec_sel = 16'hfffc;
  logic [13:0] irq_autovec;
  logic        retd_exec = 1'b0, rets_exec = 1'b0, sr_wr_en = 1'b0;
  logic [31:0] stack_ret_pc = '0, stack_ret_sr = '0, sr_wr_data = '0;
  logic        fetch_redirect_q, debug_active_flag_q, stack_push_q, stack_pop_q;
  logic        evt_taken_q, evt_old_q;
  logic [31:0] fetch_addr_q, sr_q, dbg_ret_pc_q, dbg_ret_sr_q;
  logic [31:0] stack_push_pc_q, stack_push_sr_q;
  logic [2:0]  evt_code_q;
  int          n_fail = 0, n_checks = 0;
  logic [13:0] ofs [8] = '{OFS_I_MULTI, OFS_I_MISS, OFS_I_PROT, OFS_D_MULTI,
                           OFS_D_MISS, OFS_D_PROT, OFS_SCALL, 14'h0000};
  row_s rows [17] = '{
    '{8'h01, 8'h00, 2'h0, 8'h00, 8'h00, 3'h0, 1'b1},
    '{8'h02, 8'h00, 2'h0, 8'h00, 8'h00, 3'h1, 1'b1},
    '{8'h04, 8'h00, 2'h0, 8'h00, 8'h00, 3'h2, 1'b1},
    '{8'h08, 8'h00, 2'h0, 8'h00, 8'h00, 3'h3, 1'b1},
    '{8'h10, 8'h00, 2'h0, 8'h00, 8'h00, 3'h4, 1'b1},
    '{8'h20, 8'h00, 2'h0, 8'h00, 8'h00, 3'h5, 1'b1},
    '{8'h40, 8'h00, 2'h0, 8'h00, 8'h00, 3'h6, 1'b1},
    '{8'h80, 8'h00, 2'h0, 8'h00, 8'h00, 3'h7, 1'b1},
    '{8'h50, 8'h00, 2'h0, 8'h00, 8'h00, 3'h4, 1'b1},
    '{8'h80, 8'h01, 2'h0, 8'h00, 8'h00, 3'h7, 1'b1},
    '{8'h00, 8'h04, 2'h0, 8'h00, 8'h00, 3'h2, 1'b0},
    '{8'h00, 8'h00, 2'h2, 8'h00, 8'hff, 3'h4, 1'b1},
    '{8'h00, 8'h00, 2'h2, 8'h03, 8'hff, 3'h3, 1'b1},
    '{8'h00, 8'h00, 2'h2, 8'h04, 8'h00, 3'h5, 1'b1},
    '{8'h00, 8'h00, 2'h1, 8'h10, 8'h00, 3'h2, 1'b0},
    '{8'h00, 8'h00, 2'h1, 8'h00, 8'hff, 3'h1, 1'b0},
    '{8'h00, 8'h00, 2'h1, 8'h21, 8'hff, 3'h0, 1'b0}};

  always #25 ref_clk = ~ref_clk;

  dbg_irq_model partner (.dbg_go(dbg_go), .vec_sel(vec_sel), .dbg_req(dbg_req),
                         .irq_autovec(irq_autovec));

  cpu_event_debug_entry dut (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .event_vector_base(event_vector_base),
    .ret_pc(ret_pc), .old_evt(old_evt), .young_evt(young_evt),
    .instr_acc_valid(instr_acc_valid), .instr_hit(instr_hit),
    .instr_perm_ok(instr_perm_ok), .data_acc_valid(data_acc_valid),
    .data_hit(data_hit), .data_perm_ok(data_perm_ok), .irq_autovec(irq_autovec),
    .dbg_req(dbg_req), .retd_exec(retd_exec), .rets_exec(rets_exec),
    .stack_ret_pc(stack_ret_pc), .stack_ret_sr(stack_ret_sr), .sr_wr_en(sr_wr_en),
    .sr_wr_data(sr_wr_data), .fetch_redirect_q(fetch_redirect_q),
    .fetch_addr_q(fetch_addr_q), .sr_q(sr_q), .debug_active_flag_q(debug_active_flag_q),
    .dbg_ret_pc_q(dbg_ret_pc_q), .dbg_ret_sr_q(dbg_ret_sr_q), .stack_push_q(stack_push_q),
    .stack_push_pc_q(stack_push_pc_q), .stack_push_sr_q(stack_push_sr_q),
    .stack_pop_q(stack_pop_q), .evt_taken_q(evt_taken_q), .evt_code_q(evt_code_q),
    .evt_old_q(evt_old_q));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask

  // one request cycle: requests are dropped at the edge that takes them
  task automatic go();
    @(posedge ref_clk);
    old_evt         <= '0;
    young_evt       <= '0;
    instr_acc_valid <= 1'b0;
    data_acc_valid  <= 1'b0;
    retd_exec       <= 1'b0;
    rets_exec       <= 1'b0;
    sr_wr_en        <= 1'b0;
    #1;
  endtask

  task automatic sr_write(input logic [31:0] v);
    @(posedge ref_clk);
    sr_wr_en   <= 1'b1;
    sr_wr_data <= v;
    go();
  endtask

  task automatic finish_test();
    $display("checks %0d errors %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    int k;
    repeat (4) @(posedge ref_clk);
    sys_rst <= 1'b0;
    #1;
    chk("rst_addr", RESET_VECTOR, fetch_addr_q);
    chk("rst_sr", SR_RESET, sr_q);
    chk("rst_redir", 1'b0, fetch_redirect_q);
    k = 0;
    while (fetch_redirect_q !== 1'b1 && k < 4) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("boot_redir", 1'b1, fetch_redirect_q);
    chk("boot_addr", RESET_VECTOR, fetch_addr_q);
    // no boot redirect within the bound: give up, mismatch already counted
    if (fetch_redirect_q !== 1'b1) begin
      finish_test();
    end
    foreach (rows[i]) begin
      @(posedge ref_clk);
      old_evt         <= rows[i].oe;
      young_evt       <= rows[i].ye;
      data_acc_valid  <= rows[i].acc[1];
      data_hit        <= rows[i].hit;
      data_perm_ok    <= rows[i].ok;
      instr_acc_valid <= rows[i].acc[0];
      instr_hit       <= rows[i].hit;
      instr_perm_ok   <= rows[i].ok;
      ret_pc          <= 32'h0000_0300 + i;
      go();
      chk("taken", 1'b1, evt_taken_q);
      chk("code", rows[i].code, evt_code_q);
      chk("old", rows[i].old, evt_old_q);
      chk("redir", 1'b1, fetch_redirect_q);
      chk("addr", event_vector_base + (rows[i].code == 3'h7 ? {18'h0, vec_sel[13:0]}
          : {18'h0, ofs[rows[i].code]}), fetch_addr_q);
      chk("mode", rows[i].code == 3'h6 ? MODE_SUP : rows[i].code == 3'h7 ? MODE_INT0
          : MODE_EXC, sr_q[SR_MODE_HI:SR_MODE_LO]);
      chk("push", rows[i].code == 3'h6, stack_push_q);
      if (rows[i].code == 3'h6) begin
        chk("push_pc", 32'h0000_0300 + i, stack_push_pc_q);
        // status as left by the exception rows: reset value with exception mode
        chk("push_sr", 32'h0180_0000, stack_push_sr_q);
      end
    end
    // masked request must never open debug mode
    sr_write(SR_RESET | 32'h0020_0000);
    @(posedge ref_clk);
    dbg_go <= 1'b1;
    repeat (3) begin
      go();
      chk("mask_redir", 1'b0, fetch_redirect_q);
      chk("mask_flag", 1'b0, debug_active_flag_q);
    end
    @(posedge ref_clk);
    dbg_go <= 1'b0;
    sr_wr_en <= 1'b1;
    sr_wr_data <= SR_RESET;
    go();
    chk("sr_wr", SR_RESET, sr_q);
    @(posedge ref_clk);
    ret_pc <= 32'h1234_5678;
    dbg_go <= 1'b1;
    go();
    chk("dbg_redir", 1'b1, fetch_redirect_q);
    chk("dbg_addr", event_vector_base + OFS_DEBUG, fetch_addr_q);
    chk("dbg_flag", 1'b1, debug_active_flag_q);
    chk("dbg_mode", MODE_EXC, sr_q[SR_MODE_HI:SR_MODE_LO]);
    chk("dbg_rpc", 32'h1234_5678, dbg_ret_pc_q);
    chk("dbg_rsr", SR_RESET, dbg_ret_sr_q);
    chk("dbg_push", 1'b0, stack_push_q);
    @(posedge ref_clk);
    ret_pc <= 32'h0bad_0000;
    go();
    go();
    chk("nest_redir", 1'b0, fetch_redirect_q);
    chk("nest_rpc", 32'h1234_5678, dbg_ret_pc_q);
    @(posedge ref_clk);
    dbg_go <= 1'b0;
    sr_wr_en <= 1'b1;
    sr_wr_data <= 32'h0000_0000;
    go();
    chk("dbg_wr_mode", MODE_APP, sr_q[SR_MODE_HI:SR_MODE_LO]);
    chk("dbg_wr_flag", 1'b1, debug_active_flag_q);
    @(posedge ref_clk);
    retd_exec <= 1'b1;
    go();
    chk("retd_redir", 1'b1, fetch_redirect_q);
    chk("retd_addr", 32'h1234_5678, fetch_addr_q);
    chk("retd_sr", SR_RESET, sr_q);
    @(posedge ref_clk);
    rets_exec    <= 1'b1;
    stack_ret_pc <= 32'h0000_4000;
    stack_ret_sr <= 32'h0000_0000;
    go();
    chk("rets_pop", 1'b1, stack_pop_q);
    chk("rets_addr", 32'h0000_4000, fetch_addr_q);
    chk("rets_sr", 32'h0000_0000, sr_q);
    // application mode cannot raise its own privilege
    sr_write(32'h0180_0000);
    chk("app_mode", MODE_APP, sr_q[SR_MODE_HI:SR_MODE_LO]);
    // reset in the middle of debug mode, request held across the release
    @(posedge ref_clk);
    dbg_go <= 1'b1;
    go();
    chk("dbg2_flag", 1'b1, debug_active_flag_q);
    @(posedge ref_clk);
    sys_rst <= 1'b1;
    go();
    chk("rst2_flag", 1'b0, debug_active_flag_q);
    chk("rst2_rpc", 32'h0000_0000, dbg_ret_pc_q);
    chk("rst2_sr", SR_RESET, sr_q);
    chk("rst2_addr", RESET_VECTOR, fetch_addr_q);
    @(posedge ref_clk);
    sys_rst <= 1'b0;
    go();
    // boot cycle ignores the pending request
    chk("boot2_redir", 1'b1, fetch_redirect_q);
    chk("boot2_addr", RESET_VECTOR, fetch_addr_q);
    chk("boot2_flag", 1'b0, debug_active_flag_q);
    go();
    chk("boot2_dbg", 1'b1, debug_active_flag_q);
    chk("boot2_rpc", 32'h0bad_0000, dbg_ret_pc_q);
    chk("boot2_rsr", SR_RESET, dbg_ret_sr_q);
    finish_test();
  end
endmodule // test_cpu_event_debug_entry
`default_nettype wire
